/* hw/asrc_defines.vh */
// Timing constants for the asynchronous static memory controller
`ifndef ASRC_DEFINES_VH
`define ASRC_DEFINES_VH

// Clock period in picoseconds (10 MHz)
`define ASRC_CLK_PS 100000
// Settling wait after power-up, microseconds
`define ASRC_PWRUP_US 200
`define ASRC_PWRUP_CYC ((`ASRC_PWRUP_US * 1000000) / `ASRC_CLK_PS)
// Write data setup, ns
`define ASRC_WR_SETUP_NS 25
// Write output turn-off, ns
`define ASRC_WR_TURNOFF_NS 18
// Address setup to write end and strobe widths, ns
`define ASRC_WR_PULSE_NS 35
// Address access time, ns
`define ASRC_ADDR_ACC_NS 45
// Output gate access time, ns
`define ASRC_OE_ACC_NS 22
// Select access time, ns
`define ASRC_SEL_ACC_NS 45
// Deselect power-down time, ns
`define ASRC_PD_NS 45
// Ceil of a time in ns to cycles, at least one
`define ASRC_CYC_UP(ns) ((((ns) * 1000 + `ASRC_CLK_PS - 1) / `ASRC_CLK_PS) \
	> 0 ? (((ns) * 1000 + `ASRC_CLK_PS - 1) / `ASRC_CLK_PS) : 1)
// Write strobe low cycles: max of pulse width and setup plus turn-off
`define ASRC_WR_CYC ((`ASRC_CYC_UP(`ASRC_WR_PULSE_NS) > \
	`ASRC_CYC_UP(`ASRC_WR_SETUP_NS + `ASRC_WR_TURNOFF_NS)) ? \
	`ASRC_CYC_UP(`ASRC_WR_PULSE_NS) : \
	`ASRC_CYC_UP(`ASRC_WR_SETUP_NS + `ASRC_WR_TURNOFF_NS))
// Read wait cycles: from select access time only
`define ASRC_RD_CYC `ASRC_CYC_UP(`ASRC_SEL_ACC_NS)
// Idle cycles after deselect before power-down counts as entered
`define ASRC_PD_CYC `ASRC_CYC_UP(`ASRC_PD_NS)
// Counter width
`define ASRC_CNT_W 12

`endif

/* hw/asrc_pwrup_wait.v */
// Power-up settling wait counter
`timescale 1ns/1ps
`include "asrc_defines.vh"

module asrc_pwrup_wait #(
	parameter WAIT_CYC = `ASRC_PWRUP_CYC
) (
	// Clock and reset
	input wire ref_clk,
	input wire rst_n,
	// Supply stable indication, already synchronised
	input wire supply_ok,
	// Wait complete
	output reg ready_r
);

	reg [31:0] cnt_r;

	// Count from supply stable; restart if supply drops
	always @(posedge ref_clk) begin
		if (!rst_n || !supply_ok) begin
			cnt_r <= 32'h0000_0000;
			ready_r <= 1'b0;
		end else if (cnt_r >= WAIT_CYC - 1) begin
			ready_r <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 32'h0000_0001;
		end
	end

endmodule

/* hw/asrc_ctrl.v */
// Host controller for a 256K x 16 asynchronous static memory
// Summary of operation
// - Wait 200 us after stable supply before any access.
// - Write begins with all strobes active; releasing one ends it.
// - Data valid 25 ns before terminating edge; hold from that edge.
// - Do not drive data until 18 ns after write strobe falls.
// - Strobe-ended write with gate low lasts setup plus turn-off time.
// - Write strobe stays high through every read cycle.
// - Address stable 35 ns before write end; strobes last 35 ns.
// - Address setup and hold around write are zero minimum.
// - Byte select low at least 35 ns before write end.
// - Deselect the memory before lowering supply to retention.
`timescale 1ns/1ps
`include "asrc_defines.vh"

module asrc_ctrl #(
	parameter ADDR_W = 18,
	parameter DATA_W = 16,
	parameter PWRUP_CYC = `ASRC_PWRUP_CYC,
	parameter WR_CYC = `ASRC_WR_CYC,
	parameter RD_CYC = `ASRC_RD_CYC,
	parameter PD_CYC = `ASRC_PD_CYC
) (
	// Clock and reset
	input wire ref_clk,
	input wire rst_n,
	// Supply status pin
	input wire supply_ok,
	// Request to enter data retention
	input wire retain_req,
	output wire retain_ok,
	// User request
	input wire req_valid,
	output wire req_ready,
	input wire req_write,
	input wire [ADDR_W-1:0] req_addr,
	input wire [DATA_W-1:0] req_wdata,
	input wire [1:0] req_byte_en,
	// User answer
	output reg rsp_valid_r,
	output reg [DATA_W-1:0] rsp_rdata_r,
	// Memory pins
	output reg [ADDR_W-1:0] mem_addr_r,
	output reg chip_select_n_r,
	output reg write_strobe_n_r,
	output reg output_gate_n_r,
	output reg upper_byte_select_n_r,
	output reg lower_byte_select_n_r,
	input wire [DATA_W-1:0] mem_data_in,
	output reg [DATA_W-1:0] mem_data_out_r,
	output reg mem_data_oe_n_r
);

	localparam [2:0] ST_WAIT = 3'd0;
	localparam [2:0] ST_IDLE = 3'd1;
	localparam [2:0] ST_WSET = 3'd2;
	localparam [2:0] ST_WPUL = 3'd3;
	localparam [2:0] ST_WEND = 3'd4;
	localparam [2:0] ST_RD = 3'd5;
	localparam [2:0] ST_REND = 3'd6;
	localparam [`ASRC_CNT_W-1:0] ONE = 12'h001;

	reg [2:0] state_r;
	reg [`ASRC_CNT_W-1:0] cnt_r;
	reg [`ASRC_CNT_W-1:0] idle_cnt_r;
	reg [1:0] sok_sync_r;
	reg [DATA_W-1:0] din_s1_r;
	reg [DATA_W-1:0] din_s2_r;
	wire pwr_ready;

	// Cycle count as counter width
	function [`ASRC_CNT_W-1:0] cyc;
		input integer n;
		begin
			cyc = n[`ASRC_CNT_W-1:0];
		end
	endfunction

	// Supply pin and read data pass two flip-flops
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			sok_sync_r <= 2'b00;
			din_s1_r <= 16'h0000;
			din_s2_r <= 16'h0000;
		end else begin
			sok_sync_r <= {sok_sync_r[0], supply_ok};
			din_s1_r <= mem_data_in;
			din_s2_r <= din_s1_r;
		end
	end

	asrc_pwrup_wait #(
		.WAIT_CYC(PWRUP_CYC)
	) u_pwrup (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.supply_ok(sok_sync_r[1]),
		.ready_r(pwr_ready)
	);

	assign req_ready = (state_r == ST_IDLE) && !retain_req;
	assign retain_ok = chip_select_n_r &&
		(idle_cnt_r >= cyc(PD_CYC)) && (state_r != ST_WSET);

	// Deselect time counter for retention
	always @(posedge ref_clk) begin
		if (!rst_n || !chip_select_n_r) begin
			idle_cnt_r <= 12'h000;
		end else if (idle_cnt_r < cyc(PD_CYC)) begin
			idle_cnt_r <= idle_cnt_r + ONE;
		end
	end

	// Access sequencer
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			state_r <= ST_WAIT;
			cnt_r <= 12'h000;
			rsp_valid_r <= 1'b0;
			rsp_rdata_r <= 16'h0000;
			mem_addr_r <= 18'h0_0000;
			chip_select_n_r <= 1'b1;
			write_strobe_n_r <= 1'b1;
			output_gate_n_r <= 1'b1;
			upper_byte_select_n_r <= 1'b1;
			lower_byte_select_n_r <= 1'b1;
			mem_data_out_r <= 16'h0000;
			mem_data_oe_n_r <= 1'b1;
		end else begin
			rsp_valid_r <= 1'b0;
			case (state_r)
			ST_WAIT: begin
				if (pwr_ready)
					state_r <= ST_IDLE;
			end
			ST_IDLE: begin
				if (!pwr_ready) begin
					state_r <= ST_WAIT;
				end else if (req_valid && !retain_req) begin
					mem_addr_r <= req_addr;
					cnt_r <= 12'h000;
					if (req_write) begin
						output_gate_n_r <= 1'b1;
						mem_data_out_r <= req_wdata;
						state_r <= ST_WSET;
					end else begin
						write_strobe_n_r <= 1'b1;
						mem_data_oe_n_r <= 1'b1;
						chip_select_n_r <= 1'b0;
						output_gate_n_r <= 1'b0;
						upper_byte_select_n_r <= ~req_byte_en[1];
						lower_byte_select_n_r <= ~req_byte_en[0];
						state_r <= ST_RD;
					end
				end
			end
			ST_WSET: begin
				chip_select_n_r <= 1'b0;
				write_strobe_n_r <= 1'b0;
				// both lanes stored on every write
				upper_byte_select_n_r <= 1'b0;
				lower_byte_select_n_r <= 1'b0;
				state_r <= ST_WPUL;
			end
			ST_WPUL: begin
				mem_data_oe_n_r <= 1'b0;
				cnt_r <= cnt_r + ONE;
				// strobe width, data one cycle behind
				if (cnt_r >= cyc(WR_CYC)) begin
					write_strobe_n_r <= 1'b1;
					chip_select_n_r <= 1'b1;
					upper_byte_select_n_r <= 1'b1;
					lower_byte_select_n_r <= 1'b1;
					state_r <= ST_WEND;
				end
			end
			ST_WEND: begin
				// Data hold one cycle past write end
				mem_data_oe_n_r <= 1'b1;
				rsp_valid_r <= 1'b1;
				state_r <= ST_IDLE;
			end
			ST_RD: begin
				cnt_r <= cnt_r + ONE;
				// wait select access time plus sync
				if (cnt_r >= cyc(RD_CYC) + 12'h002) begin
					rsp_rdata_r <= din_s2_r;
					chip_select_n_r <= 1'b1;
					output_gate_n_r <= 1'b1;
					upper_byte_select_n_r <= 1'b1;
					lower_byte_select_n_r <= 1'b1;
					state_r <= ST_REND;
				end
			end
			ST_REND: begin
				rsp_valid_r <= 1'b1;
				state_r <= ST_IDLE;
			end
			default: begin
				state_r <= ST_WAIT;
			end
			endcase
		end
	end

endmodule

/* tb/asrc_ctrl_props.sv */
// Pin-order checker for the memory controller
`timescale 1ns/1ps
module asrc_ctrl_props #(parameter PWRUP_CYC = 20, parameter PD_CYC = 1) (
	// Clock, reset and status
	input wire ref_clk,
	input wire rst_n,
	input wire supply_ok,
	input wire req_ready,
	input wire retain_ok,
	// Memory pins
	input wire [17:0] mem_addr_r,
	input wire chip_select_n_r,
	input wire write_strobe_n_r,
	input wire output_gate_n_r,
	input wire upper_byte_select_n_r,
	input wire lower_byte_select_n_r,
	input wire mem_data_oe_n_r
);
	reg [11:0] up_r = 12'h000;
	reg [11:0] ds_r = 12'h000;
	// Cycles of stable supply and of deselect
	always @(posedge ref_clk) begin
		up_r <= (!rst_n || !supply_ok) ? 12'h000 : up_r + {11'h0, ~&up_r};
		ds_r <= !chip_select_n_r ? 12'h000 : ds_r + {11'h0, ~&ds_r};
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	property p_up; req_ready |-> up_r >= PWRUP_CYC; endproperty
	a_up: assert property (p_up) else $error("early ready");
	property p_rd; !output_gate_n_r |-> write_strobe_n_r; endproperty
	a_rd: assert property (p_rd) else $error("write in read");
	property p_bus; !output_gate_n_r |-> mem_data_oe_n_r; endproperty
	a_bus: assert property (p_bus) else $error("bus clash");
	property p_off; $fell(write_strobe_n_r) |-> mem_data_oe_n_r; endproperty
	a_off: assert property (p_off) else $error("early drive");
	property p_pw; $fell(write_strobe_n_r) |=> !write_strobe_n_r;
	endproperty
	a_pw: assert property (p_pw) else $error("short strobe");
	property p_sd; $rose(write_strobe_n_r) |->
		!mem_data_oe_n_r && !$past(mem_data_oe_n_r); endproperty
	a_sd: assert property (p_sd) else $error("data setup");
	property p_st; $fell(write_strobe_n_r) |-> !chip_select_n_r
		&& !upper_byte_select_n_r && !lower_byte_select_n_r; endproperty
	a_st: assert property (p_st) else $error("bad start");
	property p_end; $rose(write_strobe_n_r) |-> chip_select_n_r
		&& upper_byte_select_n_r && lower_byte_select_n_r; endproperty
	a_end: assert property (p_end) else $error("bad end");
	property p_adr; (!write_strobe_n_r || $rose(write_strobe_n_r)) |->
		$stable(mem_addr_r); endproperty
	a_adr: assert property (p_adr) else $error("addr moved");
	property p_ret; retain_ok |-> chip_select_n_r && ds_r >= PD_CYC;
	endproperty
	a_ret: assert property (p_ret) else $error("early retain");
endmodule
bind asrc_ctrl asrc_ctrl_props #(.PWRUP_CYC(PWRUP_CYC), .PD_CYC(PD_CYC))
	i_asrc_ctrl_props (.ref_clk, .rst_n, .supply_ok, .req_ready, .retain_ok,
	.mem_addr_r, .chip_select_n_r, .write_strobe_n_r, .output_gate_n_r,
	.upper_byte_select_n_r, .lower_byte_select_n_r, .mem_data_oe_n_r);

/* tb/asrc_mem_model.sv */
// Behavioural static memory on the far side
`timescale 1ns/1ps
module asrc_mem_model #(parameter DLY = 45) (
	// Memory pins
	input wire [17:0] addr,
	input wire cs_n,
	input wire we_n,
	input wire og_n,
	input wire upper_byte_select_n,
	input wire lower_byte_select_n,
	// Data lines and lane drive
	input wire [15:0] bus,
	output logic [15:0] rd_q,
	output wire [1:0] rd_en
);
	logic [15:0] mem [int];
	logic [15:0] w;
	always @(addr, cs_n, we_n, upper_byte_select_n, lower_byte_select_n,
		bus) begin
		if (!cs_n && !we_n) begin
			w = mem.exists(addr) ? mem[addr] : 16'h0000;
			if (!lower_byte_select_n) w[7:0] = bus[7:0];
			if (!upper_byte_select_n) w[15:8] = bus[15:8];
			mem[addr] = w;
		end
	end
	always @(addr, cs_n, we_n, og_n) begin
		rd_q <= #(DLY) mem.exists(addr) ? mem[addr] : 16'h0000;
	end
	// drive selected lanes in reads only
	// lanes fall quiet within the delay of a deselect
	assign #(DLY) rd_en = {2{!cs_n && we_n && !og_n}}
		& ~{upper_byte_select_n, lower_byte_select_n};
endmodule

/* tb/tb_asrc_ctrl.sv */
// Self-checking bench for the memory controller
`timescale 1ns/1ps
module tb_asrc_ctrl;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic supply_ok = 1'b0;
	logic retain_req = 1'b0;
	logic req_valid = 1'b0;
	logic req_write = 1'b0;
	logic [17:0] req_addr = 18'h0_0000;
	logic [15:0] req_wdata = 16'h0000;
	logic [1:0] req_byte_en = 2'h0;
	logic [15:0] last = 16'h0000;
	logic [31:0] e;
	logic [31:0] q [$];
	logic [15:0] sh [int];
	logic [17:0] a [8];
	int err_total = 0;
	int n_tests = 0;
	wire req_ready, retain_ok, rsp_valid_r, chip_select_n_r;
	wire write_strobe_n_r, output_gate_n_r, mem_data_oe_n_r;
	wire upper_byte_select_n_r, lower_byte_select_n_r;
	wire [1:0] rd_en;
	wire [15:0] rsp_rdata_r, mem_data_out_r, mem_data_in, rd_q;
	wire [17:0] mem_addr_r;
	asrc_ctrl #(.PWRUP_CYC(20)) i_asrc_ctrl (.ref_clk, .rst_n, .supply_ok,
		.retain_req, .retain_ok, .req_valid, .req_ready, .req_write,
		.req_addr, .req_wdata, .req_byte_en, .rsp_valid_r, .rsp_rdata_r,
		.mem_addr_r, .chip_select_n_r, .write_strobe_n_r, .output_gate_n_r,
		.upper_byte_select_n_r, .lower_byte_select_n_r, .mem_data_in,
		.mem_data_out_r, .mem_data_oe_n_r);
	asrc_mem_model #(.DLY(45)) i_asrc_mem_model (.addr(mem_addr_r),
		.cs_n(chip_select_n_r), .we_n(write_strobe_n_r),
		.og_n(output_gate_n_r), .upper_byte_select_n(upper_byte_select_n_r),
		.lower_byte_select_n(lower_byte_select_n_r), .bus(mem_data_in),
		.rd_q, .rd_en);
	// Lane level: controller, memory, else a toggling pattern
	for (genvar g = 0; g < 2; g++) begin : g_lane
		assign mem_data_in[8*g+:8] = !mem_data_oe_n_r ? mem_data_out_r[8*g+:8]
			: rd_en[g] ? rd_q[8*g+:8] : ~last[8*g+:8];
	end
	always #50 ref_clk = ~ref_clk;
	always @(posedge ref_clk) last <= mem_data_in;
	task chk(input logic [15:0] got, input logic [15:0] want);
		n_tests++;
		if (got !== want) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
		end
	endtask
	task test_done;
		$display("checks %0d errors %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// One request, expectation noted first
	task xfer(input logic w, input logic [17:0] ad, input logic [15:0] d,
		input logic [1:0] be);
		if (w) sh[ad] = d;
		q.push_back(w ? 32'h0000_0000 : {{8{be[1]}}, {8{be[0]}}, sh[ad]});
		req_valid <= 1'b1;
		req_write <= w;
		req_addr <= ad;
		req_wdata <= d;
		req_byte_en <= be;
		do @(negedge ref_clk); while (req_ready !== 1'b1);
		@(posedge ref_clk);
		req_valid <= 1'b0;
		@(posedge ref_clk);
	endtask
	// Compare each answer with the oldest note
	always @(posedge ref_clk) begin
		if (rsp_valid_r === 1'b1) begin
			e = q.size() ? q.pop_front() : 32'hffff_xxxx;
			chk(rsp_rdata_r & e[31:16], e[15:0] & e[31:16]);
		end
	end
	initial begin
		void'($urandom(32'hd38e_fe34));
		repeat (5) @(posedge ref_clk);
		rst_n <= 1'b1;
		supply_ok <= 1'b1;
		// Writes at both address ends and random places
		foreach (a[i]) begin
			a[i] = i == 0 ? 18'h0_0000 : i == 1 ? 18'h3_ffff : 18'($urandom);
			xfer(1'b1, a[i], 16'($urandom), 2'($urandom));
		end
		// Reads of lower, upper and both lanes
		foreach (a[i]) xfer(1'b0, a[i], 16'($urandom), 2'(i % 3 + 1));
		while (q.size() != 0) @(posedge ref_clk);
		// Retention only after a settled deselect
		retain_req <= 1'b1;
		do @(negedge ref_clk); while (retain_ok !== 1'b1);
		chk({15'h0000, req_ready}, 16'h0000);
		test_done();
	end
	// Watchdog against a hang
	initial begin
		#(3000 * 100);
		err_total++;
		test_done();
	end
endmodule
